/* rtl/system_monitor_limit_irq.sv */
/*
 * register-side logic of an eight channel system monitor: register map,
 * round-robin monitoring loop, limit comparison and interrupt output.
 * assumes a serial bus slave outside that turns bus transfers into
 * single-cycle byte read and write strobes, and an analog front end
 * that hands in a sample for the channel being converted.
 */
// Operation
// (R01) temperature is 9-bit two's complement, half degree
// (R02) temperature limits are 8-bit, one degree steps
// (R03) high limit at 38h, hysteresis at 39h
// (R04) irq needs hold clear, enable set, violation
// (R05) voltage above high or at-below low violates
// (R06) status read returns then clears status
// (R07) clear-hold bit drops irq, halts loop
// (R08) temperature irq holds until read or hold
// (R09) temperature irq returns after next conversion
// (R10) repeats stop below hysteresis plus status read
// (R11) two tri-level pins select nine addresses
// (R12) configuration at 00h resets to 08h
// (R13) mask at 03h, zero reset, blocks irq
// (R14) rate register at 07h selects continuous mode
// (R15) channel disable at 08h skips channels
// (R16) write to 09h starts one pass
// (R17) deep shutdown at 0Ah, off at reset; the code only stores this bit, nothing shuts down
// (R18) reference and mode at 0Bh, zero reset
// (R19) activity at 0Ch reports busy, not-ready
// (R20) results at 20h-27h, 16 bit, read-only
// (R21) limits at 2Ah-39h, 8 bit, read-write
// (R22) run bit starts loop, low means shutdown
// (R23) init bit restores defaults, then self-clears
// (R24) status bits set by loop until read
`timescale 1ns/1ps
`default_nettype none

module system_monitor_limit_irq (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [1:0]  addr_select_low_pin,
    input  wire logic [1:0]  addr_select_high_pin,
    output logic      [6:0]  bus_address,
    output logic [2:0]       conv_channel,
    output logic             conv_start,
    input  wire logic [11:0] conv_sample,
    output logic             irq_n_out,
    output logic             irq_n_oe
);
    // ========================================================
    // register storage
    logic [7:0]  config_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  rate_reg;
    logic [7:0]  chan_off_reg;
    logic [7:0]  hold_reg;
    logic [7:0]  mode_reg;
    logic [15:0] result_reg [0:sysmon_pkg::NUM_CHANNELS-1];
    logic [7:0]  limit_reg  [0:15];
    logic        not_ready_reg;
    logic [15:0] ready_cnt_reg;
    logic        pass_req_reg;
    logic        temp_latched_reg;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_NEXT} loop_state_e;
    loop_state_e state_reg;
    logic [2:0]  chan_reg;
    logic [15:0] conv_cnt_reg;

    logic wr_cfg, wr_init, wr_shot, rd_flags, halted, temp_cool;
    logic [3:0] limit_idx;
    logic [7:0] violation;
    logic [7:0] set_bits;
    logic       conv_done;

    assign wr_cfg   = reg_wr && (reg_addr == sysmon_pkg::OFS_CONTROL_CONFIG);
    assign wr_init  = wr_cfg && reg_wdata[sysmon_pkg::CFG_INIT_BIT];
    assign wr_shot  = reg_wr && (reg_addr == sysmon_pkg::OFS_SINGLE_PASS);
    assign rd_flags = reg_rd && (reg_addr == sysmon_pkg::OFS_VIOLATION_FLAGS);
    assign limit_idx = 4'(reg_addr - sysmon_pkg::OFS_LIMITS_FIRST);
    // loop may not run while hold is set
    assign halted   = config_reg[sysmon_pkg::CFG_CLEAR_HOLD]; // see (R07)
    assign conv_done = (state_reg == ST_CONVERT) && (conv_cnt_reg == 16'(sysmon_pkg::CONV_CYCLES - 1));

    // ========================================================
    // address decode of the tri-level pins, 0 low 1 mid 2 high
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_address <= 7'h1d;
        end else begin
            // base plus 3*high + low gives nine addresses
            bus_address <= 7'(7'h1d + 7'(addr_select_high_pin) * 7'd3 + 7'(addr_select_low_pin)); // see (R11)
        end
    end

    // ========================================================
    // configuration register; init pulse restores defaults
    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            config_reg <= sysmon_pkg::RST_CONTROL_CONFIG; // see (R12) see (R23)
        end else if (wr_cfg) begin
            config_reg <= reg_wdata & sysmon_pkg::CFG_WRITE_MASK & 8'h7f; // see (R12)
        end
    end

    // plain control registers, zero after reset or init
    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            mask_reg     <= sysmon_pkg::RST_ZERO; // see (R13)
            rate_reg     <= sysmon_pkg::RST_ZERO; // see (R14)
            chan_off_reg <= sysmon_pkg::RST_ZERO; // see (R15)
            hold_reg     <= sysmon_pkg::RST_ZERO; // see (R17)
            mode_reg     <= sysmon_pkg::RST_ZERO; // see (R18)
        end else if (reg_wr) begin
            case (reg_addr)
                sysmon_pkg::OFS_IRQ_MASK:       mask_reg     <= reg_wdata;
                sysmon_pkg::OFS_RATE_SELECT:    rate_reg     <= reg_wdata & sysmon_pkg::RATE_WRITE_MASK;
                sysmon_pkg::OFS_CHANNEL_OFF:    chan_off_reg <= reg_wdata;
                sysmon_pkg::OFS_LOW_POWER_HOLD: hold_reg     <= reg_wdata & sysmon_pkg::HOLD_WRITE_MASK;
                sysmon_pkg::OFS_REF_INPUT_MODE: mode_reg     <= reg_wdata & sysmon_pkg::MODE_WRITE_MASK;
                default: ;
            endcase
        end
    end

    // limits are never reset, not even by init
    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr >= sysmon_pkg::OFS_LIMITS_FIRST && reg_addr <= sysmon_pkg::OFS_LIMITS_LAST) begin
            limit_reg[limit_idx] <= reg_wdata; // see (R21) see (R03)
        end
    end

    // not-ready holds for a settling time after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            not_ready_reg <= 1'b1; // see (R19)
            ready_cnt_reg <= 16'h0000;
        end else if (not_ready_reg) begin
            ready_cnt_reg <= 16'(ready_cnt_reg + 16'h0001);
            if (ready_cnt_reg == 16'(sysmon_pkg::READY_CYCLES - 1)) begin
                not_ready_reg <= 1'b0;
            end
        end
    end

    // ========================================================
    // monitoring loop: walks enabled channels in order
    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            pass_req_reg <= 1'b0;
        end else if (wr_shot) begin
            pass_req_reg <= 1'b1; // see (R16)
        end else if (state_reg == ST_IDLE && !halted && !not_ready_reg) begin
            pass_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            state_reg    <= ST_IDLE;
            chan_reg     <= 3'h0;
            conv_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    chan_reg     <= 3'h0;
                    conv_cnt_reg <= 16'h0000;
                    // run bit or a single pass request starts a pass
                    if (!halted && !not_ready_reg
                        && (config_reg[sysmon_pkg::CFG_RUN_BIT] || pass_req_reg)) begin // see (R22) see (R16)
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (chan_off_reg[chan_reg]) begin
                        state_reg <= ST_NEXT; // see (R15)
                    end else if (halted) begin
                        conv_cnt_reg <= conv_cnt_reg; // loop frozen while hold is set
                    end else if (conv_done) begin
                        state_reg <= ST_NEXT;
                    end else begin
                        conv_cnt_reg <= 16'(conv_cnt_reg + 16'h0001);
                    end
                end
                ST_NEXT: begin
                    conv_cnt_reg <= 16'h0000;
                    chan_reg     <= 3'(chan_reg + 3'h1);
                    if (chan_reg == 3'(sysmon_pkg::NUM_CHANNELS - 1)) begin
                        // low power mode drops to idle after each pass, which restarts at once while run is set; continuous needs run
                        if (rate_reg[0] && config_reg[sysmon_pkg::CFG_RUN_BIT] && !halted) begin // see (R14)
                            state_reg <= ST_CONVERT;
                        end else begin
                            state_reg <= ST_IDLE; // see (R22)
                        end
                    end else begin
                        state_reg <= ST_CONVERT;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign conv_channel = chan_reg;
    // no pulse while held, else a frozen first cycle would look like a new start
    assign conv_start   = (state_reg == ST_CONVERT) && (conv_cnt_reg == 16'h0000)
                          && !chan_off_reg[chan_reg] && !halted; // see (R07)

    // results latch at the end of each conversion; init keeps them
    always_ff @(posedge clk) begin
        if (conv_done && !halted) begin
            if (chan_reg == 3'(sysmon_pkg::TEMP_CHANNEL)) begin
                // temperature is a 9-bit two's complement in half degrees
                result_reg[chan_reg] <= {7'h00, conv_sample[8:0]}; // see (R01) see (R20)
            end else begin
                result_reg[chan_reg] <= {4'h0, conv_sample}; // see (R20)
            end
        end
    end

    // ========================================================
    // comparison; voltage limits sit as high,low pairs from 2Ah
    always_comb begin
        violation = 8'h00;
        for (int i = 0; i < sysmon_pkg::NUM_CHANNELS - 1; i++) begin
            // compare the top 8 bits of the 12-bit reading against the limits
            violation[i] = (conv_sample[11:4] > limit_reg[2*i]) || (conv_sample[11:4] <= limit_reg[2*i+1]); // see (R05)
        end
        // half degrees against the doubled limit, so half a degree above still trips
        violation[sysmon_pkg::TEMP_CHANNEL] =
            $signed(conv_sample[8:0]) > $signed({limit_reg[14], 1'b0}); // see (R05) see (R02) see (R03)
    end

    // temperature stays armed until it cools to hysteresis
    assign temp_cool = $signed(conv_sample[8:0]) <= $signed({limit_reg[15], 1'b0}); // see (R10)

    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            temp_latched_reg <= 1'b0;
        end else if (conv_done && !halted && chan_reg == 3'(sysmon_pkg::TEMP_CHANNEL)) begin
            if (violation[sysmon_pkg::TEMP_CHANNEL]) begin
                temp_latched_reg <= 1'b1;
            end else if (temp_cool) begin
                temp_latched_reg <= 1'b0; // see (R10)
            end
        end
    end

    // status bits raised by the loop in this cycle
    always_comb begin
        set_bits = 8'h00;
        if (conv_done && !halted) begin
            if (chan_reg == 3'(sysmon_pkg::TEMP_CHANNEL)) begin
                // re-raised each conversion until cooled and read
                set_bits[sysmon_pkg::TEMP_CHANNEL] =
                    violation[sysmon_pkg::TEMP_CHANNEL] || (temp_latched_reg && !temp_cool); // see (R09) see (R10)
            end else begin
                set_bits[chan_reg] = violation[chan_reg]; // see (R24)
            end
        end
    end

    // status register: cleared by reading; set wins so no event is lost
    always_ff @(posedge clk) begin
        if (srst || wr_init) begin
            flags_reg <= sysmon_pkg::RST_ZERO;
        end else if (rd_flags) begin
            flags_reg <= set_bits; // see (R06) see (R08)
        end else begin
            flags_reg <= flags_reg | set_bits; // see (R24) see (R08)
        end
    end

    // ========================================================
    // interrupt pin, open drain, low while a masked-in flag stands, enable is set and hold is clear
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_oe <= !config_reg[sysmon_pkg::CFG_CLEAR_HOLD]
                     && config_reg[sysmon_pkg::CFG_IRQ_EN_BIT]
                     && |(flags_reg & ~mask_reg); // see (R04) see (R07) see (R13)
        end
    end
    assign irq_n_out = 1'b0;

    // ========================================================
    // read data, registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr >= sysmon_pkg::OFS_RESULTS_FIRST && reg_addr <= sysmon_pkg::OFS_RESULTS_LAST) begin
                reg_rdata <= result_reg[3'(reg_addr)]; // see (R20)
            end else if (reg_addr >= sysmon_pkg::OFS_LIMITS_FIRST && reg_addr <= sysmon_pkg::OFS_LIMITS_LAST) begin
                reg_rdata <= {8'h00, limit_reg[limit_idx]}; // see (R21)
            end else begin
                case (reg_addr)
                    sysmon_pkg::OFS_CONTROL_CONFIG:  reg_rdata <= {8'h00, config_reg};
                    sysmon_pkg::OFS_VIOLATION_FLAGS: reg_rdata <= {8'h00, flags_reg}; // see (R06)
                    sysmon_pkg::OFS_IRQ_MASK:        reg_rdata <= {8'h00, mask_reg};
                    sysmon_pkg::OFS_RATE_SELECT:     reg_rdata <= {8'h00, rate_reg};
                    sysmon_pkg::OFS_CHANNEL_OFF:     reg_rdata <= {8'h00, chan_off_reg};
                    sysmon_pkg::OFS_LOW_POWER_HOLD:  reg_rdata <= {8'h00, hold_reg};
                    sysmon_pkg::OFS_REF_INPUT_MODE:  reg_rdata <= {8'h00, mode_reg};
                    sysmon_pkg::OFS_ACTIVITY:        reg_rdata <= {14'h0000, not_ready_reg,
                                                                   state_reg != ST_IDLE}; // see (R19)
                    sysmon_pkg::OFS_MAKER_CODE:      reg_rdata <= {8'h00, sysmon_pkg::MAKER_CODE_VALUE};
                    sysmon_pkg::OFS_REVISION_CODE:   reg_rdata <= {8'h00, sysmon_pkg::REVISION_CODE_VALUE};
                    default:                         reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

/* rtl/sysmon_pkg.sv */
/*
 * constants of the system monitor register block: offsets, fields,
 * reset values and loop timing.
 * assumes a 100 MHz clock and a byte-wide register port.
 */
package sysmon_pkg;
    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_CONTROL_CONFIG   = 8'h00;
    localparam logic [7:0] OFS_VIOLATION_FLAGS  = 8'h01;
    localparam logic [7:0] OFS_IRQ_MASK         = 8'h03;
    localparam logic [7:0] OFS_RATE_SELECT      = 8'h07;
    localparam logic [7:0] OFS_CHANNEL_OFF      = 8'h08;
    localparam logic [7:0] OFS_SINGLE_PASS      = 8'h09;
    localparam logic [7:0] OFS_LOW_POWER_HOLD   = 8'h0a;
    localparam logic [7:0] OFS_REF_INPUT_MODE   = 8'h0b;
    localparam logic [7:0] OFS_ACTIVITY         = 8'h0c;
    localparam logic [7:0] OFS_RESULTS_FIRST    = 8'h20;
    localparam logic [7:0] OFS_RESULTS_LAST     = 8'h27;
    localparam logic [7:0] OFS_LIMITS_FIRST     = 8'h2a;
    localparam logic [7:0] OFS_LIMITS_LAST      = 8'h39;
    localparam logic [7:0] OFS_TEMP_HIGH        = 8'h38;
    localparam logic [7:0] OFS_TEMP_HYST        = 8'h39;
    localparam logic [7:0] OFS_MAKER_CODE       = 8'h3e;
    localparam logic [7:0] OFS_REVISION_CODE    = 8'h3f;
    // ========================================================
    // reset values
    localparam logic [7:0] RST_CONTROL_CONFIG   = 8'h08;
    localparam logic [7:0] RST_ACTIVITY         = 8'h02;
    localparam logic [7:0] RST_ZERO             = 8'h00;
    // identity values, arbitrary
    localparam logic [7:0] MAKER_CODE_VALUE     = 8'h5a;
    localparam logic [7:0] REVISION_CODE_VALUE  = 8'h01;
    // ========================================================
    // field positions
    localparam int CFG_RUN_BIT       = 0;
    localparam int CFG_IRQ_EN_BIT    = 1;
    localparam int CFG_CLEAR_HOLD    = 3;
    localparam int CFG_INIT_BIT      = 7;
    localparam int ACT_BUSY_BIT      = 0;
    localparam int ACT_NOT_READY_BIT = 1;
    localparam int TEMP_CHANNEL      = 7;
    localparam int NUM_CHANNELS      = 8;
    // writable bit masks
    localparam logic [7:0] CFG_WRITE_MASK  = 8'h8b;
    localparam logic [7:0] RATE_WRITE_MASK = 8'h01;
    localparam logic [7:0] HOLD_WRITE_MASK = 8'h01;
    localparam logic [7:0] MODE_WRITE_MASK = 8'h07;
    // ========================================================
    // timing
    localparam int CLK_FREQ_HZ        = 100_000_000;
    localparam int CONV_TIME_NS       = 1000;
    localparam int CONV_CYCLES        = CONV_TIME_NS / (1_000_000_000 / CLK_FREQ_HZ);
    localparam int READY_TIME_NS      = 2000;
    localparam int READY_CYCLES       = READY_TIME_NS / (1_000_000_000 / CLK_FREQ_HZ);
endpackage

/* tb/sysmon_front_end.sv */
/* stand-in for the analog front end: one sample per channel.
   assumes the bench changes the codes only between conversions. */
`timescale 1ns/1ps
`default_nettype none
module sysmon_front_end (
    input  wire logic [2:0]  conv_channel,
    input  wire logic [8:0]  temp_code,
    input  wire logic [11:0] volt_code,
    output logic      [11:0] conv_sample
);
    // ========================================================
    // sign-extend temperature so the upper bits never look stale
    assign conv_sample = (conv_channel == 3'(sysmon_pkg::TEMP_CHANNEL)) ?
                         {{3{temp_code[8]}}, temp_code} : volt_code;
endmodule
`default_nettype wire

/* tb/sysmon_monitor.sv */
/* port checker of the monitor block.
   assumes it is bound onto system_monitor_limit_irq. */
`timescale 1ns/1ps
`default_nettype none
module sysmon_monitor (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0]  addr_select_low_pin,
    input wire logic [1:0]  addr_select_high_pin,
    input wire logic [6:0]  bus_address,
    input wire logic [2:0]  conv_channel,
    input wire logic        conv_start,
    input wire logic [11:0] conv_sample,
    input wire logic        irq_n_out,
    input wire logic        irq_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] cfg_q;
    int         rdy_cnt;
    // ========================================================
    // shadow of the control byte; init bit self-clears to defaults
    always_ff @(posedge clk) begin
        if (srst)
            cfg_q <= sysmon_pkg::RST_CONTROL_CONFIG;
        else if (reg_wr && reg_addr == sysmon_pkg::OFS_CONTROL_CONFIG)
            cfg_q <= reg_wdata[7] ? sysmon_pkg::RST_CONTROL_CONFIG : (reg_wdata & 8'h0b);
    end
    // cycles since reset, saturating
    always_ff @(posedge clk) begin
        if (srst)
            rdy_cnt <= 0;
        else if (rdy_cnt < sysmon_pkg::READY_CYCLES)
            rdy_cnt <= rdy_cnt + 1;
    end
    // ========================================================
    // properties
    property p_drive_low; irq_n_oe |-> !irq_n_out; endproperty
    a_drive_low: assert property (p_drive_low) else $error("irq pin driven high");
    property p_enable_off; !cfg_q[1] [*3] |-> !irq_n_oe; endproperty
    a_enable_off: assert property (p_enable_off) else $error("irq with enable off");
    property p_hold_quiet; cfg_q[3] [*3] |-> !irq_n_oe && !conv_start; endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("irq or loop during hold");
    property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_one_shot_zero; reg_rd && reg_addr == sysmon_pkg::OFS_SINGLE_PASS |=> reg_rdata == 16'h0000;
    endproperty
    a_one_shot_zero: assert property (p_one_shot_zero) else $error("trigger reads nonzero");
    property p_cfg_read; reg_rd && reg_addr == 8'h00 |=> reg_rdata == {8'h00, $past(cfg_q)}; endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("control byte mismatch");
    property p_addr;
        1'b1 |=> bus_address == 7'h1d + 7'(3 * $past(addr_select_high_pin)) + 7'($past(addr_select_low_pin));
    endproperty
    a_addr: assert property (p_addr) else $error("bus address mismatch");
    property p_chan_hold; conv_start |=> $stable(conv_channel) [*8]; endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved in conversion");
    property p_not_ready; rdy_cnt < sysmon_pkg::READY_CYCLES - 2 |-> !conv_start; endproperty
    a_not_ready: assert property (p_not_ready) else $error("conversion while not ready");
    c_irq: cover property (irq_n_oe);
    c_temp: cover property (conv_start && conv_channel == 3'd7);
    c_status_rd: cover property (reg_rd && reg_addr == 8'h01);
endmodule
bind system_monitor_limit_irq sysmon_monitor i_sysmon_monitor (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_select_low_pin(addr_select_low_pin), .addr_select_high_pin(addr_select_high_pin),
    .bus_address(bus_address), .conv_channel(conv_channel), .conv_start(conv_start),
    .conv_sample(conv_sample), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire

/* tb/system_monitor_limit_irq_test.sv */
/* self-checking bench of the monitor block.
   assumes the front-end stand-in and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module system_monitor_limit_irq_test;
    logic        clk = 1'b0;
    logic        srst, reg_wr, reg_rd, conv_start, irq_n_out, irq_n_oe;
    logic [7:0]  reg_addr, reg_wdata;
    logic [1:0]  sel_lo, sel_hi;
    logic [15:0] reg_rdata, d;
    logic [6:0]  bus_address;
    logic [2:0]  conv_channel;
    logic [11:0] conv_sample, volt_code;
    logic [8:0]  temp_code;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [7:0]  rst_ofs [10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h02};
    logic [7:0]  rst_val [10] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    system_monitor_limit_irq i_system_monitor_limit_irq (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .addr_select_low_pin(sel_lo), .addr_select_high_pin(sel_hi), .bus_address(bus_address),
        .conv_channel(conv_channel), .conv_start(conv_start), .conv_sample(conv_sample),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    sysmon_front_end i_sysmon_front_end (.conv_channel(conv_channel), .temp_code(temp_code),
        .volt_code(volt_code), .conv_sample(conv_sample));
    // ========================================================
    // clock and tasks
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // data is taken one edge late; it stands until the next read
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
        chk($sformatf("reg %h", a), exp, d);
    endtask
    // waits until the next temperature conversion has finished
    task automatic wait_temp;
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (!(conv_start && conv_channel == 3'd7) && n < 4000) begin
            @(posedge clk);
            #1 n++;
        end
        chk("temperature conversion seen", 16'h0001, {15'h0, n < 4000});
        repeat (sysmon_pkg::CONV_CYCLES + 4) @(posedge clk);
        #1;
    endtask
    task automatic irq(input logic e);
        chk("irq active", {15'h0, e}, {15'h0, irq_n_oe});
    endtask
    function automatic logic [7:0] lim(input int a);
        return a == 'h38 ? 8'h19 : a == 'h39 ? 8'h14 : a[0] ? 8'h00 : 8'hff;
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ========================================================
    // watchdog, well beyond the nine passes the run needs
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // ========================================================
    // main sequence
    initial begin
        {srst, reg_wr, reg_rd, reg_addr, reg_wdata, sel_lo, sel_hi} = {3'b100, 20'h0};
        temp_code = 9'h032;
        volt_code = 12'h800;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) rchk(rst_ofs[i], {8'h00, rst_val[i]});
        for (int h = 0; h < 3; h++) begin
            for (int l = 0; l < 3; l++) begin
                @(posedge clk);
                sel_hi <= 2'(h);
                sel_lo <= 2'(l);
                repeat (2) @(posedge clk);
                #1 chk("bus address", 16'(7'h1d + 7'(3 * h + l)), {9'h0, bus_address});
            end
        end
        for (int a = 'h2a; a <= 'h39; a++) wr(8'(a), lim(a));
        for (int a = 'h2a; a <= 'h39; a++) rchk(8'(a), {8'h00, lim(a)});
        repeat (sysmon_pkg::READY_CYCLES) @(posedge clk);
        rchk(8'h0c, 16'h0000);
        wr(8'h07, 8'h01);
        wr(8'h00, 8'h03);
        // 25 C equals the 25 C limit, so no violation
        wait_temp();
        irq(1'b0);
        rchk(8'h01, 16'h0000);
        temp_code <= 9'h03c;
        wait_temp();
        irq(1'b1);
        rchk(8'h01, 16'h0080);
        @(posedge clk);
        #1 irq(1'b0);
        // 22 C sits above hysteresis, so the interrupt comes back
        temp_code <= 9'h02c;
        wait_temp();
        irq(1'b1);
        rchk(8'h01, 16'h0080);
        temp_code <= 9'h01e;
        wait_temp();
        rchk(8'h01, 16'h0000);
        wait_temp();
        irq(1'b0);
        wr(8'h2b, 8'h80);
        wait_temp();
        irq(1'b1);
        rchk(8'h01, 16'h0001);
        wr(8'h03, 8'h01);
        wait_temp();
        irq(1'b0);
        rchk(8'h01, 16'h0001);
        wr(8'h03, 8'h00);
        wait_temp();
        wr(8'h00, 8'h0b);
        repeat (3) @(posedge clk);
        #1 irq(1'b0);
        rchk(8'h01, 16'h0001);
        wr(8'h00, 8'h80);
        rchk(8'h00, 16'h0008);
        rchk(8'h03, 16'h0000);
        rchk(8'h38, 16'h0019);
        rchk(8'h20, 16'h0800);
        // one pass on demand, loop stopped, voltage channels off
        temp_code <= 9'h03c;
        wr(8'h08, 8'h7f);
        wr(8'h00, 8'h02);
        wr(8'h09, 8'h00);
        wait_temp();
        irq(1'b1);
        rchk(8'h01, 16'h0080);
        rchk(8'h27, 16'h003c);
        rchk(8'h0c, 16'h0000);
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rchk(8'h00, 16'h0008);
        give_verdict();
    end
endmodule
`default_nettype wire
